// >>> verilog/aoaf_consts.svh
// Register map, field positions, reset values and sizes of the ADC
// oversampling/averaging filter; shared by the package and the modules.
// Assumes the includer wants plain `define constants only.
`ifndef AOAF_CONSTS_SVH
`define AOAF_CONSTS_SVH

// Widths of the register port and the data paths
`define AOAF_ADDR_W      4
`define AOAF_DATA_W      16
`define AOAF_SAMPLE_W    12
`define AOAF_SUM_W       20
`define AOAF_CHAN_W      5
`define AOAF_CNT_W       9
`define AOAF_LOG2_W      4

// Register offsets on the plain register port
`define AOAF_OFF_CTRL    4'h0
`define AOAF_OFF_RESULT  4'h1
`define AOAF_OFF_STATUS  4'h2
`define AOAF_OFF_MASK    4'h3
`define AOAF_OFF_CHAN    4'h4

// Control register fields
`define AOAF_EN_BIT      15
`define AOAF_MODE_MSB    14
`define AOAF_MODE_LSB    13
`define AOAF_RATIO_MSB   12
`define AOAF_RATIO_LSB   10
`define AOAF_IRQEN_BIT   9
`define AOAF_RDY_BIT     8

// Mode codes
`define AOAF_MODE_AVG    2'h3
`define AOAF_MODE_OVS    2'h0

// Interrupt status bits
`define AOAF_STS_W       2
`define AOAF_STS_DONE    0
`define AOAF_STS_OVR     1

// Reset values
`define AOAF_CTRL_RST    16'h0000
`define AOAF_MASK_RST    2'h0
`define AOAF_CHAN_RST    5'h00

`endif

// >>> verilog/aoaf_pkg.sv
// Types of the ADC oversampling/averaging filter.
// Assumes aoaf_consts.svh is on the include path.
`include "aoaf_consts.svh"

package aoaf_pkg;

  // Filter sequencing state, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } aoaf_state_t;

  typedef logic [`AOAF_DATA_W-1:0] aoaf_word_t;

endpackage : aoaf_pkg

// >>> verilog/aoaf_accum.sv
// Sample accumulator: sums 2**log2n samples, then hands the sum out.
// Assumes samples arrive on the same clock and log2n holds steady
// between clears.
`timescale 1ns/1ns
`include "aoaf_consts.svh"

module aoaf_accum
  import aoaf_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      resetn_i,
  // Control
  input  wire logic                      clear_i,
  input  wire logic [`AOAF_LOG2_W-1:0]   log2n_i,
  // Samples in
  input  wire logic                      sample_vld_i,
  input  wire logic [`AOAF_SAMPLE_W-1:0] sample_i,
  // Sum out
  output logic                           done_o,
  output logic [`AOAF_SUM_W-1:0]         sum_o
);

  logic [`AOAF_SUM_W-1:0] acc_q;
  logic [`AOAF_CNT_W-1:0] cnt_q;
  logic [`AOAF_CNT_W-1:0] last_cnt;
  logic                   last_smp;
  logic [`AOAF_SUM_W-1:0] acc_sum;

  // Index of the final sample of one block
  assign last_cnt = `AOAF_CNT_W'((`AOAF_CNT_W+1)'(1) << log2n_i) - 9'h001;
  assign last_smp = sample_vld_i && (cnt_q == last_cnt);
  assign acc_sum  = acc_q + `AOAF_SUM_W'(sample_i);

  // Accumulate; the last sample closes the block and restarts at zero
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      acc_q  <= '0;
      cnt_q  <= '0;
      done_o <= 1'b0;
      sum_o  <= '0;
    end
    else if (clear_i)
    begin
      acc_q  <= '0;
      cnt_q  <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= last_smp;                         // [R9]
      if (last_smp)
      begin
        sum_o <= acc_sum;                         // [R9]
        acc_q <= '0;
        cnt_q <= '0;
      end
      else if (sample_vld_i)
      begin
        acc_q <= acc_sum;
        cnt_q <= cnt_q + 9'h001;
      end
    end
  end

endmodule : aoaf_accum

// >>> verilog/aoaf_filter.sv
// ADC oversampling/averaging result filter: control, result and IRQ.
// Assumes conversion results come from logic on core_clk_i, one cycle
// each, and a register master that never waits.
//
// What this block does
// R1 - Filter runs only while enabled; disabling clears the ready flag.
// R2 - Mode field 11 averages, 00 oversamples; 10 and 01 are reserved.
// R3 - Oversampling ratio codes give 4,16,64,256,2,8,32,128 samples.
// R4 - Oversampling results are 13 to 16 bits, 12.1 up to 12.4 format.
// R5 - Averaging ratio codes give 2,4,8,16,32,64,128,256 samples.
// R6 - Interrupt enable set raises the common interrupt on ready results while the done mask bit is set.
// R7 - Ready flag sets on new result, clears when result is read.
// R8 - Ratio field meaning depends on the current mode.
// R9 - Accumulate exactly the selected count of the channel, then restart.
`timescale 1ns/1ns
`include "aoaf_consts.svh"

module aoaf_filter
  import aoaf_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      resetn_i,
  // Register port
  input  wire logic [`AOAF_ADDR_W-1:0]   reg_addr_i,
  input  wire logic [`AOAF_DATA_W-1:0]   reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic      [`AOAF_DATA_W-1:0]   reg_rdata_o,
  // Conversion results
  input  wire logic                      conv_valid_i,
  input  wire logic [`AOAF_CHAN_W-1:0]   conv_chan_i,
  input  wire logic [`AOAF_SAMPLE_W-1:0] conv_data_i,
  // Status
  output logic                           result_ready_o,
  output logic                           irq_o
);

  // Control fields and state
  logic                      filter_enable_q;
  logic [1:0]                mode_q;
  logic [2:0]                filter_ratio_select_q;
  logic                      filter_irq_enable_q;
  logic                      rdy_q;
  aoaf_word_t                result_q;
  logic [`AOAF_STS_W-1:0]    sts_q;
  logic [`AOAF_STS_W-1:0]    mask_q;
  logic [`AOAF_CHAN_W-1:0]   chan_q;
  aoaf_word_t                rdata_q;
  aoaf_state_t               state_q;
  aoaf_state_t               state_d;

  // Control reset fields come from one word so they cannot drift apart
  localparam aoaf_word_t     ctrl_rst = `AOAF_CTRL_RST;

  // Register decode
  wire wr_ctrl   = reg_wr_i && (reg_addr_i == `AOAF_OFF_CTRL);
  wire wr_status = reg_wr_i && (reg_addr_i == `AOAF_OFF_STATUS);
  wire wr_mask   = reg_wr_i && (reg_addr_i == `AOAF_OFF_MASK);
  wire wr_chan   = reg_wr_i && (reg_addr_i == `AOAF_OFF_CHAN);
  wire rd_result = reg_rd_i && (reg_addr_i == `AOAF_OFF_RESULT);

  // Reserved mode codes keep the filter idle rather than guess a ratio
  wire mode_avg  = (mode_q == `AOAF_MODE_AVG);                 // [R2]
  wire mode_ovs  = (mode_q == `AOAF_MODE_OVS);                 // [R2]
  wire run_ok    = filter_enable_q && (mode_avg || mode_ovs);  // [R1] [R2]
  wire running   = (state_q == ST_RUN);

  // Ratio decode; the same code means different counts per mode
  wire [2:0] frac_bits = {1'b0, filter_ratio_select_q[1:0]} + 3'h1;
  wire [3:0] log2_ovs  = filter_ratio_select_q[2]
                         ? {frac_bits, 1'b0} - 4'h1
                         : {frac_bits, 1'b0};                  // [R3]
  wire [3:0] log2_avg  = {1'b0, filter_ratio_select_q} + 4'h1; // [R5]
  wire [3:0] log2n     = mode_avg ? log2_avg : log2_ovs;       // [R8]
  // Oversampling keeps frac_bits extra bits; averaging keeps none
  wire [3:0] shift     = mode_avg ? log2_avg
                                  : log2_ovs - {1'b0, frac_bits}; // [R4]

  // Accumulator control; a control write restarts the current block
  wire sample_vld = running && conv_valid_i
                    && (conv_chan_i == chan_q);                // [R9]
  wire acc_clear  = !running || wr_ctrl;
  wire acc_done;
  wire [`AOAF_SUM_W-1:0] acc_sum;
  wire [`AOAF_SUM_W-1:0] scaled = acc_sum >> shift;
  wire result_new = acc_done && running;

  // Read data mux; unmapped offsets read zero
  wire [`AOAF_DATA_W-1:0] ctrl_rd = {filter_enable_q, mode_q,
                                     filter_ratio_select_q,
                                     filter_irq_enable_q, rdy_q, 8'h00};
  wire [`AOAF_DATA_W-1:0] rdata_d =
      (reg_addr_i == `AOAF_OFF_CTRL)   ? ctrl_rd :
      (reg_addr_i == `AOAF_OFF_RESULT) ? result_q :
      (reg_addr_i == `AOAF_OFF_STATUS) ? {14'h0000, sts_q} :
      (reg_addr_i == `AOAF_OFF_MASK)   ? {14'h0000, mask_q} :
      (reg_addr_i == `AOAF_OFF_CHAN)   ? {11'h000, chan_q} : 16'h0000;

  // Interrupt events only when the filter may interrupt at all
  wire [`AOAF_STS_W-1:0] sts_set = {result_new && rdy_q && !rd_result,
                                    result_new}
                                   & {`AOAF_STS_W{filter_irq_enable_q}}; // [R6]
  wire [`AOAF_STS_W-1:0] sts_d   =
      (sts_q & ~(wr_status ? reg_wdata_i[`AOAF_STS_W-1:0] : 2'h0))
      | sts_set;  // Set wins over a same-cycle clear

  // Ready flag: a finished result beats a read in the same cycle
  wire rdy_d = !filter_enable_q ? 1'b0 :                       // [R1]
               result_new       ? 1'b1 :                       // [R7]
               rd_result        ? 1'b0 : rdy_q;                // [R7]

  aoaf_accum u_accum (
    .core_clk_i   (core_clk_i),
    .resetn_i     (resetn_i),
    .clear_i      (acc_clear),
    .log2n_i      (log2n),
    .sample_vld_i (sample_vld),
    .sample_i     (conv_data_i),
    .done_o       (acc_done),
    .sum_o        (acc_sum)
  );

  // Sequencer next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (run_ok) state_d = ST_RUN;
      ST_RUN:  if (!run_ok) state_d = ST_IDLE;                 // [R1]
      default: state_d = ST_IDLE;
    endcase
  end

  // Control register
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      filter_enable_q       <= ctrl_rst[`AOAF_EN_BIT];
      mode_q                <= ctrl_rst[`AOAF_MODE_MSB:`AOAF_MODE_LSB];
      filter_ratio_select_q <= ctrl_rst[`AOAF_RATIO_MSB:`AOAF_RATIO_LSB];
      filter_irq_enable_q   <= ctrl_rst[`AOAF_IRQEN_BIT];
    end
    else if (wr_ctrl)
    begin
      filter_enable_q       <= reg_wdata_i[`AOAF_EN_BIT];
      mode_q                <= reg_wdata_i[`AOAF_MODE_MSB:`AOAF_MODE_LSB];
      filter_ratio_select_q <= reg_wdata_i[`AOAF_RATIO_MSB:`AOAF_RATIO_LSB];
      filter_irq_enable_q   <= reg_wdata_i[`AOAF_IRQEN_BIT];
    end
  end

  // Mask, channel and read-data registers
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mask_q  <= `AOAF_MASK_RST;
      chan_q  <= `AOAF_CHAN_RST;
      rdata_q <= 16'h0000;
    end
    else
    begin
      if (wr_mask)
        mask_q <= reg_wdata_i[`AOAF_STS_W-1:0];
      if (wr_chan)
        chan_q <= reg_wdata_i[`AOAF_CHAN_W-1:0];
      rdata_q <= reg_rd_i ? rdata_d : 16'h0000;
    end
  end

  // Result, ready flag, status and sequencer state
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      result_q <= 16'h0000;
      rdy_q    <= 1'b0;
      sts_q    <= 2'h0;
      state_q  <= ST_IDLE;
    end
    else
    begin
      if (result_new)
        result_q <= scaled[`AOAF_DATA_W-1:0];                  // [R4] [R5]
      rdy_q   <= rdy_d;
      sts_q   <= sts_d;
      state_q <= state_d;
    end
  end

  assign reg_rdata_o    = rdata_q;
  assign result_ready_o = rdy_q;
  assign irq_o          = |(sts_q & mask_q);                   // [R6]

  // Checking helpers: samples taken since the last block closed
  logic [`AOAF_CNT_W:0] chk_cnt_q;
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      chk_cnt_q <= '0;
    else if (acc_clear)
      chk_cnt_q <= '0;
    else
      chk_cnt_q <= (acc_done ? 10'h000 : chk_cnt_q)
                   + {9'h000, sample_vld};
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_dis_clears_rdy;
    !filter_enable_q |=> !rdy_q [*2];
  endproperty
  a_dis_clears_rdy: assert property (p_dis_clears_rdy) // [R1]
    else $error("ready flag set while filter disabled");

  property p_reserved_idle;
    filter_enable_q && !mode_avg && !mode_ovs |=> !running;
  endproperty
  a_reserved_idle: assert property (p_reserved_idle) // [R2]
    else $error("filter running in a reserved mode");

  property p_ovs_width;
    result_new && mode_ovs
      |=> (result_q >> (5'd12 + {2'b00, $past(frac_bits)})) == 16'h0000;
  endproperty
  a_ovs_width: assert property (p_ovs_width) // [R4]
    else $error("oversampled result wider than its format");

  property p_ovs_ratio;
    mode_ovs |-> (log2n == (filter_ratio_select_q[2]
                  ? {filter_ratio_select_q[1:0], 2'b00} >> 1 | 4'h1
                  : {filter_ratio_select_q[1:0], 1'b0} + 4'h2));
  endproperty
  a_ovs_ratio: assert property (p_ovs_ratio) // [R3]
    else $error("oversampling ratio decode wrong");

  property p_avg_width;
    result_new && mode_avg |=> result_q[15:12] == 4'h0;
  endproperty
  a_avg_width: assert property (p_avg_width) // [R5]
    else $error("average exceeds sample width");

  property p_irq_gated;
    $rose(sts_q[`AOAF_STS_DONE]) |-> $past(filter_irq_enable_q);
  endproperty
  a_irq_gated: assert property (p_irq_gated) // [R6]
    else $error("filter event without interrupt enable");

  property p_rdy_on_result;
    result_new && filter_enable_q |=> rdy_q ##0 result_ready_o;
  endproperty
  a_rdy_on_result: assert property (p_rdy_on_result) // [R7]
    else $error("ready flag missed a new result");

  property p_read_clears;
    rd_result && !result_new |=> !rdy_q;
  endproperty
  a_read_clears: assert property (p_read_clears) // [R7]
    else $error("result read left ready flag set");

  property p_avg_ratio;
    mode_avg |-> (10'h001 << log2n) == (10'h002 << filter_ratio_select_q);
  endproperty
  a_avg_ratio: assert property (p_avg_ratio) // [R8]
    else $error("averaging ratio decode wrong");

  property p_block_count;
    result_new |-> chk_cnt_q == (10'h001 << log2n);
  endproperty
  a_block_count: assert property (p_block_count) // [R9]
    else $error("block closed with wrong sample count");

  property p_dis_stops;
    !filter_enable_q |=> !running;
  endproperty
  a_dis_stops: assert property (p_dis_stops) // [R1]
    else $error("filter still running after disable");

  // A mask write in the same cycle may hide the interrupt, so skip it
  property p_irq_on_result;
    result_new && filter_irq_enable_q && mask_q[`AOAF_STS_DONE] && !wr_mask
      |=> irq_o;
  endproperty
  a_irq_on_result: assert property (p_irq_on_result) // [R6]
    else $error("enabled result raised no interrupt");

  property p_rdy_holds;
    rdy_q && !rd_result && filter_enable_q |=> rdy_q;
  endproperty
  a_rdy_holds: assert property (p_rdy_holds) // [R7]
    else $error("ready flag dropped without a read");

  property p_rdy_stays_clear;
    !rdy_q && !result_new |=> !rdy_q;
  endproperty
  a_rdy_stays_clear: assert property (p_rdy_stays_clear) // [R7]
    else $error("ready flag set without a new result");

  c_ovs_result: cover property (result_new && mode_ovs);
  c_avg_result: cover property (result_new && mode_avg);
  c_irq:        cover property ($rose(irq_o));
  c_read_clear: cover property (rdy_q && rd_result ##1 !rdy_q);
  c_overrun:    cover property (result_new && rdy_q);

endmodule : aoaf_filter

// >>> verif/aoaf_conv_model.sv
// Model of the ADC conversion cores that feed the result filter.
// Assumes one clock shared with the filter; a burst starts on start_i.
`timescale 1ns/1ns

module aoaf_conv_model
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // Burst request from the bench
  input  wire logic        start_i,
  input  wire logic [8:0]  count_i,
  input  wire logic [4:0]  chan_i,
  input  wire logic        slow_i,
  // Conversion results
  output logic             conv_valid_o,
  output logic [4:0]       conv_chan_o,
  output logic [11:0]      conv_data_o,
  output logic             busy_o
);
  logic [8:0] left_q;
  logic [8:0] idx_q;
  logic       gap_q;

  // Busy until the last sample has left the bus
  assign busy_o = (left_q != 9'h000) || conv_valid_o;

  // One sample a cycle, or every other cycle when slow; between samples
  // the bus churns so a stale value is never taken for a fresh one
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      left_q       <= 9'h000;
      idx_q        <= 9'h000;
      gap_q        <= 1'b0;
      conv_valid_o <= 1'b0;
      conv_chan_o  <= 5'h00;
      conv_data_o  <= 12'h000;
    end
    else if (start_i)
    begin
      left_q       <= count_i;
      idx_q        <= 9'h000;
      gap_q        <= 1'b0;
      conv_valid_o <= 1'b0;
    end
    else if ((left_q != 9'h000) && !gap_q)
    begin
      conv_valid_o <= 1'b1;
      conv_chan_o  <= chan_i;
      conv_data_o  <= {3'h0, idx_q} * 12'h025 + 12'h064;
      idx_q        <= idx_q + 9'h001;
      left_q       <= left_q - 9'h001;
      gap_q        <= slow_i;
    end
    else
    begin
      conv_valid_o <= 1'b0;
      conv_chan_o  <= ~conv_chan_o;
      conv_data_o  <= ~conv_data_o;
      gap_q        <= 1'b0;
    end
  end
endmodule : aoaf_conv_model

// >>> verif/testbench.sv
// Self-checking bench of the filter: register port, sample bursts, IRQ.
// Assumes aoaf_consts.svh on the include path and the conversion model.
`timescale 1ns/1ns

module testbench
  import aoaf_pkg::*;
;
  typedef struct {logic [1:0] mode; logic [2:0] ratio; int n; int sh;}
    aoaf_row_t;

  // Mode, ratio code, samples per result, right shift of the sum
  aoaf_row_t rows [16] = '{
    '{2'h0, 3'h0, 4, 1}, '{2'h0, 3'h1, 16, 2}, '{2'h0, 3'h2, 64, 3},
    '{2'h0, 3'h3, 256, 4}, '{2'h0, 3'h4, 2, 0}, '{2'h0, 3'h5, 8, 1},
    '{2'h0, 3'h6, 32, 2}, '{2'h0, 3'h7, 128, 3}, '{2'h3, 3'h0, 2, 1},
    '{2'h3, 3'h1, 4, 2}, '{2'h3, 3'h2, 8, 3}, '{2'h3, 3'h3, 16, 4},
    '{2'h3, 3'h4, 32, 5}, '{2'h3, 3'h5, 64, 6}, '{2'h3, 3'h6, 128, 7},
    '{2'h3, 3'h7, 256, 8}};

  logic       core_clk_i   = 1'b0;
  logic       resetn_i     = 1'b0;
  logic [3:0] reg_addr_i   = 4'h0;
  aoaf_word_t reg_wdata_i  = 16'h0000;
  logic       reg_wr_i     = 1'b0;
  logic       reg_rd_i     = 1'b0;
  aoaf_word_t reg_rdata_o;
  logic       conv_valid_i;
  logic [4:0] conv_chan_i;
  logic [11:0] conv_data_i;
  logic       result_ready_o;
  logic       irq_o;
  logic       start_q      = 1'b0;
  logic [8:0] cnt_q        = 9'h000;
  logic [4:0] chn_q        = 5'h00;
  logic       slow_q       = 1'b0;
  logic       busy;
  int         err_count    = 0;
  int         cmp_count    = 0;
  int         cyc          = 0;
  aoaf_word_t rd;

  aoaf_filter u_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .conv_valid_i(conv_valid_i), .conv_chan_i(conv_chan_i),
    .conv_data_i(conv_data_i), .result_ready_o(result_ready_o),
    .irq_o(irq_o));

  aoaf_conv_model u_model (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .start_i(start_q), .count_i(cnt_q), .chan_i(chn_q), .slow_i(slow_q),
    .conv_valid_o(conv_valid_i), .conv_chan_o(conv_chan_i),
    .conv_data_o(conv_data_i), .busy_o(busy));

  // 20 MHz clock
  always #25 core_clk_i = ~core_clk_i;

  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task chk(input string nm, input aoaf_word_t seen, input aoaf_word_t ex);
    cmp_count++;
    if (seen !== ex)
    begin
      $display("ERROR %s expected %h seen %h", nm, ex, seen);
      err_count++;
    end
  endtask : chk

  // One-cycle write strobe
  task wr(input logic [3:0] a, input aoaf_word_t d);
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data only stand in the following cycle
  task rdr(input logic [3:0] a);
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    @(negedge core_clk_i);
    rd = reg_rdata_o;
  endtask : rdr

  // Burst of samples, then the two edges the result takes to land
  task burst(input int n, input logic [4:0] ch, input logic s);
    int g;
    g = 0;
    @(posedge core_clk_i);
    start_q <= 1'b1;
    cnt_q   <= n[8:0];
    chn_q   <= ch;
    slow_q  <= s;
    @(posedge core_clk_i);
    start_q <= 1'b0;
    @(negedge core_clk_i);
    while (busy && g < 2000)
    begin
      @(negedge core_clk_i);
      g++;
    end
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : burst

  // Sum of the model's first n samples, shifted down
  function automatic aoaf_word_t exp_res(int n, int sh);
    int s;
    s = 0;
    for (int k = 0; k < n; k++)
      s += (k * 37 + 100) % 4096;
    return 16'(s >> sh);
  endfunction : exp_res

  initial
  begin
    repeat (16) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    chk("ready", result_ready_o, 16'h0000);
    chk("irq", irq_o, 16'h0000);
    for (int a = 0; a < 6; a++)
    begin
      rdr(4'(a));
      chk("reset reg", rd, 16'h0000);
    end
    wr(4'h3, 16'h0001);
    rdr(4'h3);
    chk("mask", rd, 16'h0001);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(4'h0, {1'b1, rows[i].mode, rows[i].ratio, 1'b1, 9'h000});
      burst(rows[i].n, 5'h00, i[0]);
      chk("ready", result_ready_o, 16'h0001);
      chk("irq", irq_o, 16'h0001);
      rdr(4'h2);
      chk("status", rd, 16'h0001);
      rdr(4'h1);
      chk("result", rd, exp_res(rows[i].n, rows[i].sh));
      chk("ready clr", result_ready_o, 16'h0000);
      wr(4'h2, 16'h0001);
      @(negedge core_clk_i);
      chk("irq clr", irq_o, 16'h0000);
    end
    $display("test ratio table done");
    wr(4'h4, 16'h0003);
    wr(4'h0, 16'he000);
    burst(4, 5'h00, 1'b0);
    chk("other chan", result_ready_o, 16'h0000);
    burst(2, 5'h03, 1'b0);
    rdr(4'h1);
    chk("chan result", rd, exp_res(2, 1));
    burst(2, 5'h03, 1'b1);
    chk("ready", result_ready_o, 16'h0001);
    wr(4'h0, 16'h0000);
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("disable", result_ready_o, 16'h0000);
    burst(4, 5'h03, 1'b0);
    chk("idle", result_ready_o, 16'h0000);
    wr(4'h4, 16'h0000);
    $display("test channel and disable done");
    for (int m = 1; m < 3; m++)
    begin
      wr(4'h0, {1'b1, 2'(m), 13'h0000});
      burst(4, 5'h00, 1'b1);
      chk("reserved", result_ready_o, 16'h0000);
    end
    wr(4'h0, 16'he000);
    burst(2, 5'h00, 1'b0);
    chk("ready", result_ready_o, 16'h0001);
    chk("irq off", irq_o, 16'h0000);
    rdr(4'h2);
    chk("status off", rd, 16'h0000);
    rdr(4'h1);
    chk("result", rd, exp_res(2, 1));
    $display("test reserved and irq enable done");
    // Two results with no read between: overrun, ready seen in control
    wr(4'h0, 16'he200);
    burst(2, 5'h00, 1'b0);
    burst(2, 5'h00, 1'b0);
    rdr(4'h2);
    chk("overrun", rd, 16'h0003);
    rdr(4'h0);
    chk("ctrl", rd, 16'he300);
    // Reset in mid-run must drop ready, interrupt and control
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(negedge core_clk_i);
    chk("reset ready", result_ready_o, 16'h0000);
    chk("reset irq", irq_o, 16'h0000);
    rdr(4'h0);
    chk("reset ctrl", rd, 16'h0000);
    $display("test overrun and reset done");
    end_of_test();
  end
endmodule : testbench
